// ### verilog/pde_ctrl.sv
/*
 * Power-down entry control: decides whether a power-down instruction enters
 * power-down, is ignored, or leaves the cpu quasi-idle on affected silicon.
 * Assumes the cpu gives a one-cycle instruction strobe with the bus context
 * of that moment, and that the watchdog and reset logic live outside.
 */
`timescale 1ns/1ps
module pde_ctrl
  import pde_pkg::*;
#(
  parameter int unsigned WAKE_PINS = pde_pkg::PDE_WAKE_PINS,
  // 0 models fixed silicon: the erratum path is never taken
  parameter bit AFFECTED_SILICON = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // instruction flow
  input wire logic power_down_instruction,
  input wire logic next_code_external,
  input wire logic prev_write_external,
  // bus configuration from the system config register
  input wire logic bus_multiplexed,
  input wire logic memory_tristate_wait_bit,
  input wire logic power_down_exit_select,
  // wake-up sources
  input wire logic nmi_n,
  input wire logic [WAKE_PINS-1:0] wake_pins_active,
  // status and control out
  output logic fetch_stop_q,
  output logic in_power_down_q,
  output logic quasi_idle_q,
  output logic irq_block_q,
  output logic wake_done_q,
  output logic instr_ignored_q,
  output logic periph_clk_en_q
);
  import pde_pkg::*;

  // ********************************************
  // wake source decode
  // ********************************************
  function automatic logic wake_source_active(input logic sel, input logic nmi_low_n,
                                              input logic [WAKE_PINS-1:0] pins);
    wake_source_active = sel ? (|pins) : nmi_low_n;
  endfunction
  // limitation: wake pins are taken as settled, synchronous levels

  pde_state_t state_q;
  pde_state_t state_d;
  logic blocked;
  logic quasi_hit;

  // blocked doubles as the wake condition once in power-down
  assign blocked = wake_source_active(power_down_exit_select, nmi_n, wake_pins_active);
  // the erratum path: external code after the instruction with a risky bus history
  // write history comes from the instruction just before the strobe
  assign quasi_hit = AFFECTED_SILICON && next_code_external &&
                     ((bus_multiplexed && !memory_tristate_wait_bit) || prev_write_external);

  // ********************************************
  // state machine
  // ********************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      PDE_RUN: begin
        // erratum check first: on affected parts it wins over the ignore test
        if (power_down_instruction) begin
          if (quasi_hit) begin
            state_d = PDE_QUASI;
          end else if (!blocked) begin
            state_d = PDE_POWER_DOWN;
          end
        end
      end
      PDE_QUASI: begin
        // only a low interrupt pin releases it; watchdog reset is the other exit
        if (!nmi_n) begin
          state_d = PDE_POWER_DOWN;
        end
      end
      PDE_POWER_DOWN: begin
        // a strobe here is refused; only the wake source moves the state
        if (blocked) begin
          state_d = PDE_RUN;
        end
      end
      default: begin
        // unused code: recover to run
        state_d = PDE_RUN;
      end
    endcase
  end

  // a watchdog reset arrives on rst_n; nothing here counts it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PDE_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ********************************************
  // registered outputs
  // ********************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_stop_q <= PDE_RST_FETCH_STOP;
      in_power_down_q <= PDE_RST_IN_POWER_DOWN;
      quasi_idle_q <= PDE_RST_QUASI;
      irq_block_q <= PDE_RST_IRQ_BLOCK;
      periph_clk_en_q <= PDE_RST_PERIPH_EN;
    end else begin
      // decoded from the next state so every flag lines up with state_q
      fetch_stop_q <= (state_d != PDE_RUN);
      in_power_down_q <= (state_d == PDE_POWER_DOWN);
      quasi_idle_q <= (state_d == PDE_QUASI);
      irq_block_q <= (state_d == PDE_QUASI);
      // peripherals only stop in true power-down, so the watchdog still counts in quasi-idle
      periph_clk_en_q <= (state_d != PDE_POWER_DOWN);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_done_q <= PDE_RST_DONE;
      instr_ignored_q <= PDE_RST_IGNORED;
    end else begin
      wake_done_q <= (state_q == PDE_POWER_DOWN) && (state_d == PDE_RUN);
      // back-to-back ignored strobes give a pulse longer than one cycle
      instr_ignored_q <= (state_q == PDE_RUN) && power_down_instruction && !quasi_hit && blocked;
    end
  end

  // ********************************************
  // checks
  // ********************************************
  // decisions one cycle after a strobe taken in run
  ignore_nmi_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == PDE_RUN && power_down_instruction && !quasi_hit && !power_down_exit_select && nmi_n)
      |=> (!in_power_down_q && instr_ignored_q && !fetch_stop_q))
    else $error("instruction not ignored with interrupt pin high");
  ignore_pins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == PDE_RUN && power_down_instruction && !quasi_hit && power_down_exit_select && |wake_pins_active)
      |=> (!in_power_down_q && instr_ignored_q))
    else $error("instruction not ignored with wake pin active");
  down_enter_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == PDE_RUN && power_down_instruction && !quasi_hit && !blocked)
      |=> (in_power_down_q && fetch_stop_q && !periph_clk_en_q))
    else $error("power-down not entered");

  // erratum path: only with external code after the instruction
  quasi_mux_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == PDE_RUN && power_down_instruction && AFFECTED_SILICON && next_code_external &&
     bus_multiplexed && !memory_tristate_wait_bit) |=> quasi_idle_q)
    else $error("quasi-idle missed on multiplexed bus");
  quasi_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == PDE_RUN && power_down_instruction && AFFECTED_SILICON && next_code_external &&
     prev_write_external) |=> (quasi_idle_q && !in_power_down_q))
    else $error("quasi-idle missed after external write");
  quasi_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == PDE_RUN && power_down_instruction && !(AFFECTED_SILICON && next_code_external))
      |=> !quasi_idle_q)
    else $error("quasi-idle entered without external code");

  // quasi-idle: cpu off the bus and off interrupts, peripherals still run
  quasi_fetch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    quasi_idle_q |-> (fetch_stop_q && !in_power_down_q))
    else $error("fetch running in quasi-idle");
  quasi_stay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == PDE_QUASI && nmi_n) |=> (quasi_idle_q && fetch_stop_q))
    else $error("quasi-idle left without interrupt pin low");
  fetch_run_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!quasi_idle_q && !in_power_down_q) |-> !fetch_stop_q)
    else $error("fetch stopped while running");
  quasi_periph_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    quasi_idle_q |-> periph_clk_en_q)
    else $error("peripherals stopped in quasi-idle");
  periph_run_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !in_power_down_q |-> periph_clk_en_q)
    else $error("peripherals stopped outside power-down");
  quasi_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    quasi_idle_q |-> irq_block_q)
    else $error("interrupts open in quasi-idle");
  irq_open_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !quasi_idle_q |-> !irq_block_q)
    else $error("interrupts blocked outside quasi-idle");
  quasi_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == PDE_QUASI && !nmi_n) |=> (in_power_down_q && !quasi_idle_q))
    else $error("quasi-idle did not proceed to power-down");

  // power-down, and strobes that arrive while the cpu is halted
  down_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (in_power_down_q && !blocked) |=> in_power_down_q)
    else $error("power-down left without wake source");
  down_wake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == PDE_POWER_DOWN && blocked) |=> (wake_done_q && !in_power_down_q && !fetch_stop_q))
    else $error("no resume on wake source");
  wake_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wake_done_q |=> !wake_done_q)
    else $error("wake pulse longer than one cycle");
  busy_refuse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q != PDE_RUN && power_down_instruction) |=> !instr_ignored_q)
    else $error("strobe acted on while halted");
  down_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    in_power_down_q |-> (!quasi_idle_q && !irq_block_q && fetch_stop_q && !periph_clk_en_q))
    else $error("power-down outputs inconsistent");

endmodule

// ### verilog/pde_pkg.sv
/*
 * Shared constants and types for the power-down entry control block.
 * Assumes a single 200 MHz core clock and an active-low asynchronous reset.
 */
package pde_pkg;

  // ********************************************
  // widths and reset values
  // ********************************************
  localparam int unsigned PDE_WAKE_PINS = 16;
  localparam logic PDE_RST_FETCH_STOP = 1'b0;
  localparam logic PDE_RST_IN_POWER_DOWN = 1'b0;
  localparam logic PDE_RST_QUASI = 1'b0;
  localparam logic PDE_RST_IRQ_BLOCK = 1'b0;
  localparam logic PDE_RST_DONE = 1'b0;
  localparam logic PDE_RST_IGNORED = 1'b0;
  localparam logic PDE_RST_PERIPH_EN = 1'b1;

  // ********************************************
  // controller states
  // ********************************************
  typedef enum logic [1:0] {
    PDE_RUN = 2'b00,
    PDE_QUASI = 2'b01,
    PDE_POWER_DOWN = 2'b10
  } pde_state_t;

endpackage

// ### bench/pde_far_side.sv
/* far side of the block: external bus context and wake-up pin levels.
   assumes the bench changes want only at the falling clock edge. */
`timescale 1ns/1ps
module pde_far_side
  import pde_pkg::*;
(
  // requested conditions
  input wire logic [3:0] want,
  // to the block
  output logic code_ext,
  output logic wr_ext,
  output logic nmi_n,
  output logic [PDE_WAKE_PINS-1:0] wake
);
  // software may put code after the instruction in external memory anyway
  assign code_ext = want[0];
  // an external write just before the instruction, as software is told to do
  assign wr_ext = want[1];
  assign nmi_n = ~want[2];
  // one pin in the middle, so a narrow or-reduction is caught
  assign wake = {{(PDE_WAKE_PINS - 6){1'b0}}, want[3], 5'h00};
endmodule

// ### bench/power_down_entry_control_tb.sv
/* scenario bench for the power-down entry control block.
   assumes the far-side model drives bus context and wake-up pins. */
`timescale 1ns/1ps
module power_down_entry_control_tb;
  import pde_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pdi = 1'b0;
  logic mux = 1'b0;
  logic wbit = 1'b1;
  logic sel = 1'b0;
  logic [3:0] want = 4'h0;
  logic code_ext, wr_ext, nmi_n, fs, pd, qi, ib, wd, ig, pc;
  logic [PDE_WAKE_PINS-1:0] wake;
  logic [3:0] seen;
  int fails = 0;
  int n_compared = 0;
  pde_far_side far_u (.want(want), .code_ext(code_ext), .wr_ext(wr_ext), .nmi_n(nmi_n), .wake(wake));
  pde_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .power_down_instruction(pdi), .next_code_external(code_ext),
    .prev_write_external(wr_ext), .bus_multiplexed(mux), .memory_tristate_wait_bit(wbit),
    .power_down_exit_select(sel), .nmi_n(nmi_n), .wake_pins_active(wake), .fetch_stop_q(fs), .in_power_down_q(pd),
    .quasi_idle_q(qi), .irq_block_q(ib), .wake_done_q(wd), .instr_ignored_q(ig), .periph_clk_en_q(pc));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // pulses are or-ed over a few cycles, so latency choice does not matter
  task automatic gather();
    seen = {wd, ig, pd, qi};
    repeat (3) @(negedge core_clk) seen = seen | {wd, ig, pd, qi};
  endtask
  task automatic fire();
    @(negedge core_clk) pdi = 1'b1;
    @(negedge core_clk) pdi = 1'b0;
    gather();
  endtask
  task automatic t_nmi();
    sel = 1'b0;
    want = 4'h4;
    fire();
    chk({seen, pd, fs, pc, qi}, 8'h2C);
    fire();
    chk({seen, pd}, 8'h05);
    want = 4'h0;
    gather();
    chk({seen, pd, fs, pc}, 8'h51);
    fire();
    chk({seen, pd}, 8'h08);
    $display("test nmi done");
  endtask
  task automatic t_pins();
    sel = 1'b1;
    want = 4'h8;
    fire();
    chk({seen, pd}, 8'h08);
    want = 4'h0;
    fire();
    chk({pd, fs, pc}, 8'h06);
    want = 4'h8;
    gather();
    chk({seen, pd, pc}, 8'h29);
    $display("test pins done");
  endtask
  task automatic t_quasi();
    sel = 1'b0;
    mux = 1'b1;
    wbit = 1'b0;
    want = 4'h1;
    fire();
    chk({seen[2:0], qi, ib, fs, pc, pd}, 8'h3E);
    want = 4'h5;
    gather();
    chk({qi, ib, pd, pc}, 8'h02);
    wbit = 1'b1;
    want = 4'h0;
    gather();
    want = 4'h5;
    fire();
    chk({qi, pd}, 8'h01);
    want = 4'h1;
    gather();
    mux = 1'b0;
    want = 4'h3;
    fire();
    chk({qi, ib, pc}, 8'h07);
    fire();
    chk({seen, qi, ib}, 8'h07);
    @(negedge core_clk) rst_n = 1'b0;
    @(negedge core_clk) rst_n = 1'b1;
    chk({qi, ib, fs, pc}, 8'h01);
    $display("test quasi done");
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    test_done();
  end
  initial begin
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    t_nmi();
    t_pins();
    t_quasi();
    test_done();
  end
endmodule
